// ===== shared/pmr_params.svh
// Purpose: Offsets, reset values and field positions of the PLL multiplier and range registers.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Definitions only.
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH
`define PMR_OFF_VCO_RANGE 12'h03A
`define PMR_OFF_MUL_LOW 12'h040
`define PMR_OFF_PLL_CTRL 12'h044
`define PMR_RST_VCO_RANGE 8'h40
`define PMR_RST_MUL_LOW 8'h40
`define PMR_BIT_PLL_ON 0
`define PMR_BIT_BCS 1
`endif

// ===== shared/pmr_pkg.sv
// Purpose: Types for the PLL multiplier and range registers.
// Assumes: Nothing beyond the params header.
// Notes: Types only.
package pmr_pkg;
    typedef logic [7:0] pmr_byte_t;
    typedef enum logic [1:0] {PMR_IDLE, PMR_ACCESS} pmr_phase_t;
endpackage

// ===== logic/pmr_regs.sv
// Purpose: PLL multiplier select, VCO range select and a small PLL control register on APB.
// Assumes: pclk at 40 MHz, presetn asynchronous active low, zero-wait APB slave.
// Notes: Offset 0x03A is not word aligned, so it is an index; byte address is four times each index.
// What this block does
// R1 - Writes to the multiplier bits are ignored while the PLL is on.
// R2 - A multiplier value of zero drives the feedback divider as one.
// R3 - Reset loads the multiplier register with 0x40, factor 64.
// R4 - Multiplier bits form the low byte of the feedback divider.
// R5 - Writes to the VCO range bits are ignored while the PLL is on.
// R6 - A zero range value disables the PLL and clears base clock select.
// R7 - Base clock select cannot be set while range bits are all zero.
// R8 - Reset loads the VCO range register with 0x40, factor 64.
// R9 - Range bits drive the center-of-range multiplier output.
// R10 - Blocked writes keep stored values; reads return current contents.
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`include "pmr_params.svh"
module pmr_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] feedback_div_low,
    output logic [7:0] vco_range_mult,
    output logic pll_enable,
    output logic base_clock_vco
);
    pmr_pkg::pmr_byte_t mul_q;
    pmr_pkg::pmr_byte_t vrs_q;
    logic pll_on_q;
    logic bcs_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic setup;
    logic wr;
    logic hit_vrs;
    logic hit_mul;
    logic hit_ctl;
    logic range_zero;

    // The slave answers in the setup cycle so the access phase ends at once.
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign hit_vrs = paddr[13:2] == `PMR_OFF_VCO_RANGE;
    assign hit_mul = paddr[13:2] == `PMR_OFF_MUL_LOW;
    assign hit_ctl = paddr[13:2] == `PMR_OFF_PLL_CTRL;
    assign range_zero = vrs_q == 8'h00;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mul_q <= `PMR_RST_MUL_LOW; // R3
        end else if (wr && hit_mul && !pll_on_q) begin
            mul_q <= pwdata[7:0]; // R1 R10
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vrs_q <= `PMR_RST_VCO_RANGE; // R8
        end else if (wr && hit_vrs && !pll_on_q) begin
            vrs_q <= pwdata[7:0]; // R5 R10
        end
    end

    // A zero range forces the PLL off and the base clock back to the crystal.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_on_q <= 1'b0;
            bcs_q <= 1'b0;
        end else if (range_zero) begin
            pll_on_q <= 1'b0; // R6
            bcs_q <= 1'b0; // R6 R7
        end else if (wr && hit_ctl) begin
            pll_on_q <= pwdata[`PMR_BIT_PLL_ON];
            bcs_q <= pwdata[`PMR_BIT_BCS];
        end
    end

    // Read data and error are captured in setup and held through the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= !(hit_vrs || hit_mul || hit_ctl);
            if (hit_vrs) begin
                prdata_q <= {24'h000000, vrs_q}; // R10
            end else if (hit_mul) begin
                prdata_q <= {24'h000000, mul_q}; // R10
            end else if (hit_ctl) begin
                prdata_q <= {30'h00000000, bcs_q, pll_on_q};
            end else begin
                prdata_q <= 32'h00000000;
            end
        end
    end

    assign feedback_div_low = (mul_q == 8'h00) ? 8'h01 : mul_q; // R2 R4
    assign vco_range_mult = vrs_q; // R9
    assign pll_enable = pll_on_q && !range_zero; // R6
    assign base_clock_vco = bcs_q && !range_zero; // R7

    a_mul_locked: assert property (@(posedge pclk) disable iff (!presetn)
        pll_on_q |=> $stable(mul_q)) else $error("multiplier changed while pll on"); // R1
    a_mul_zero: assert property (@(posedge pclk) disable iff (!presetn)
        mul_q == 8'h00 |-> feedback_div_low == 8'h01) else $error("zero multiplier not treated as one"); // R2
    a_mul_wr: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit_mul && !pll_on_q |=> mul_q == $past(pwdata[7:0])) else $error("multiplier write lost"); // R4
    a_vrs_locked: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit_vrs && pll_on_q |=> vrs_q == $past(vrs_q)) else $error("range changed while pll on"); // R5
    a_zero_off: assert property (@(posedge pclk) disable iff (!presetn)
        range_zero |=> !pll_on_q && !bcs_q) else $error("zero range left pll on"); // R6
    a_bcs_block: assert property (@(posedge pclk) disable iff (!presetn)
        range_zero |-> !base_clock_vco) else $error("vco selected with zero range"); // R7
    a_vrs_out: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit_vrs && !pll_on_q |=> vco_range_mult == $past(pwdata[7:0])) else $error("range not applied"); // R9
    a_read_back: assert property (@(posedge pclk) disable iff (!presetn)
        setup && hit_mul |=> prdata[7:0] == $past(mul_q) && prdata[31:8] == 24'h000000)
        else $error("multiplier readback wrong"); // R10
endmodule

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the PLL multiplier and VCO range registers.
// Assumes: Zero-wait APB slave; byte address is four times the word index.
// Notes: No random stimulus; all inputs change by non-blocking assignment on the rising edge.
`timescale 1ns/100ps
`include "pmr_params.svh"
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, er, pll_enable, base_clock_vco;
    logic [7:0] feedback_div_low, vco_range_mult;
    int err_total = 0, num_checks = 0;
    localparam logic [13:0] A_RNG = {`PMR_OFF_VCO_RANGE, 2'b00};
    localparam logic [13:0] A_MUL = {`PMR_OFF_MUL_LOW, 2'b00};
    localparam logic [13:0] A_CTL = {`PMR_OFF_PLL_CTRL, 2'b00};
    pmr_regs i_pmr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .feedback_div_low(feedback_div_low), .vco_range_mult(vco_range_mult), .pll_enable(pll_enable),
        .base_clock_vco(base_clock_vco));
    always #12.5 pclk = ~pclk;
    task automatic final_report();
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, pready, 1'b1);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [13:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(A_RNG, 32'h0000_0040);
        rdc(A_MUL, 32'h0000_0040);
        chk({30'h0, er, pready}, 32'h0000_0001);
        chk({24'h0, vco_range_mult}, 32'h0000_0040);
        apb(1'b1, A_MUL, 32'h0000_0000); #1 chk({24'h0, feedback_div_low}, 32'h0000_0001);
        rdc(A_MUL, 32'h0000_0000);
        apb(1'b1, A_MUL, 32'h0000_005A); #1 chk({24'h0, feedback_div_low}, 32'h0000_005A);
        apb(1'b1, A_RNG, 32'h0000_0081); #1 chk({24'h0, vco_range_mult}, 32'h0000_0081);
        apb(1'b1, A_CTL, 32'h0000_0003); #1 chk({30'h0, pll_enable, base_clock_vco}, 32'h0000_0003);
        apb(1'b1, A_MUL, 32'h0000_0011); rdc(A_MUL, 32'h0000_005A);
        chk({24'h0, feedback_div_low}, 32'h0000_005A);
        apb(1'b1, A_RNG, 32'h0000_0000); rdc(A_RNG, 32'h0000_0081);
        chk({24'h0, vco_range_mult}, 32'h0000_0081);
        apb(1'b1, A_CTL, 32'h0000_0000); apb(1'b1, A_RNG, 32'h0000_0000);
        apb(1'b1, A_CTL, 32'h0000_0003); #1 chk({30'h0, pll_enable, base_clock_vco}, 32'h0000_0000);
        rdc(A_CTL, 32'h0000_0000);
        apb(1'b1, A_RNG, 32'h0000_0001); apb(1'b1, A_CTL, 32'h0000_0002);
        #1 chk({30'h0, pll_enable, base_clock_vco}, 32'h0000_0001);
        rdc(14'h3FFC, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        final_report();
    end
    initial begin
        #100000;
        err_total++;
        final_report();
    end
endmodule
